//--- design/ctms_regs.vh
// register offsets, field positions, reset values and output mode codes for the clock test-mode select block
// ==========================================================================
`ifndef CTMS_REGS_VH
`define CTMS_REGS_VH
// ==========================================================================
// register map
`define CTMS_CTRL_OFFSET    12'h000
`define CTMS_STATUS_OFFSET  12'h004
// ==========================================================================
// control fields
`define CTMS_ENTRY_BIT      0
`define CTMS_CHOICE_BIT     1
`define CTMS_CTRL_RESET     32'h00000000
// ==========================================================================
// status fields
`define CTMS_ST_HW_BIT      0
`define CTMS_ST_SW_BIT      1
`define CTMS_ST_HIZ_BIT     2
`define CTMS_ST_REF_BIT     3
// ==========================================================================
// output modes
`define CTMS_OUT_NORMAL     2'h0
`define CTMS_OUT_HIZ        2'h1
`define CTMS_OUT_REF        2'h2
`endif

//--- design/ctms_mode_sel.v
// combinational output-mode decode for the clock test-mode select block
`timescale 1ns/1ps
`include "ctms_regs.vh"
module ctms_mode_sel
(
   // mode state
   input  wire       hw_test,
   input  wire       sw_test,
   // selectors
   input  wire       test_output_select_pin,
   input  wire       output_choice_bit,
   // result
   output reg  [1:0] out_mode
);
   always @*
   begin
      if (hw_test)
      begin
         if (!test_output_select_pin && !output_choice_bit)
            out_mode = `CTMS_OUT_HIZ;
         else
            out_mode = `CTMS_OUT_REF;
      end
      else if (sw_test)
      begin
         // pin deliberately not looked at here
         if (output_choice_bit)
            out_mode = `CTMS_OUT_REF;
         else
            out_mode = `CTMS_OUT_HIZ;
      end
      else
         out_mode = `CTMS_OUT_NORMAL;
   end
endmodule

//--- design/ctms_top.v
// clock output test-mode select with apb control registers
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ctms_regs.vh"
module ctms_top
(
   // apb
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // pins
   input  wire        test_latch_select_pin,
   input  wire        test_output_select_pin,
   // output control
   output reg         outputs_hiz,
   output reg         outputs_ref,
   output reg         test_active
);
   // ========================================================================
   // state
   reg        strap_done_reg;
   reg        hw_test_reg;
   reg        sw_test_reg;
   reg        entry_reg;
   reg        choice_reg;
   wire [1:0] out_mode;
   wire       acc;
   wire       wr;
   wire       ctrl_hit;
   wire       stat_hit;

   assign acc      = psel & penable;
   assign wr       = acc & pwrite;
   assign ctrl_hit = (paddr == `CTMS_CTRL_OFFSET);
   assign stat_hit = (paddr == `CTMS_STATUS_OFFSET);

   // ========================================================================
   // power-up strap and sticky test modes
   // presetn stands for power-up; nothing else ever clears the mode flags
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         strap_done_reg <= 1'b0;
         hw_test_reg    <= 1'b0;
         sw_test_reg    <= 1'b0;
      end
      else
      begin
         if (!strap_done_reg)
         begin
            strap_done_reg <= 1'b1;
            hw_test_reg    <= test_latch_select_pin;
         end
         // software entry only possible when strap read low
         if (strap_done_reg && !hw_test_reg && entry_reg)
            sw_test_reg <= 1'b1;
      end
   end

   // ========================================================================
   // control register
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         entry_reg  <= 1'b0;
         choice_reg <= 1'b0;
      end
      else if (wr && ctrl_hit)
      begin
         // entry bit is sticky: writing zero cannot leave test mode
         entry_reg  <= entry_reg | pwdata[`CTMS_ENTRY_BIT];
         choice_reg <= pwdata[`CTMS_CHOICE_BIT];
      end
   end

   ctms_mode_sel u_sel
   (
      .hw_test                (hw_test_reg),
      .sw_test                (sw_test_reg),
      .test_output_select_pin (test_output_select_pin),
      .output_choice_bit      (choice_reg),
      .out_mode               (out_mode)
   );

   // ========================================================================
   // registered outputs
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         outputs_hiz <= 1'b0;
         outputs_ref <= 1'b0;
         test_active <= 1'b0;
      end
      else
      begin
         outputs_hiz <= (out_mode == `CTMS_OUT_HIZ);
         outputs_ref <= (out_mode == `CTMS_OUT_REF);
         test_active <= hw_test_reg | sw_test_reg;
      end
   end

   // ========================================================================
   // apb slave: answers in the access cycle, read data registered at setup
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~(ctrl_hit | stat_hit);
         prdata  <= 32'h00000000;
         if (psel && !penable && !pwrite)
         begin
            if (ctrl_hit)
            begin
               prdata[`CTMS_ENTRY_BIT]  <= entry_reg;
               prdata[`CTMS_CHOICE_BIT] <= choice_reg;
            end
            else if (stat_hit)
            begin
               prdata[`CTMS_ST_HW_BIT]  <= hw_test_reg;
               prdata[`CTMS_ST_SW_BIT]  <= sw_test_reg;
               prdata[`CTMS_ST_HIZ_BIT] <= (out_mode == `CTMS_OUT_HIZ);
               prdata[`CTMS_ST_REF_BIT] <= (out_mode == `CTMS_OUT_REF);
            end
         end
      end
   end
endmodule

//--- test/ctms_board.sv
// board strap and pin model for the test-mode select block
`timescale 1ns/1ps
module ctms_board
(
   input  logic strap_set,
   input  logic sel_set,
   output logic test_latch_select_pin,
   output logic test_output_select_pin
);
   // strap only means anything while power comes up
   assign test_latch_select_pin = strap_set;
   assign test_output_select_pin = sel_set;
endmodule

//--- test/ctms_top_properties.sv
// port checker for ctms_top
`timescale 1ns/1ps
module ctms_chk
(
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pready,
   input logic pslverr,
   input logic test_latch_select_pin,
   input logic outputs_hiz,
   input logic outputs_ref,
   input logic test_active
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_strap; $rose(presetn) && test_latch_select_pin |-> ##2 test_active; endproperty
   property p_stick; test_active |=> test_active; endproperty
   property p_one; test_active |-> outputs_hiz ^ outputs_ref; endproperty
   property p_norm; !test_active |-> !outputs_hiz && !outputs_ref; endproperty
   property p_nostrap; $rose(presetn) && !test_latch_select_pin |=> !test_active; endproperty
   property p_ready; psel && !penable |=> pready; endproperty
   property p_pulse; pready |=> !pready; endproperty
   property p_err; pslverr |-> pready; endproperty
   a_strap: assert property (p_strap) else $error("strap did not enter test");
   a_stick: assert property (p_stick) else $error("test mode left");
   a_one: assert property (p_one) else $error("test output state wrong");
   a_norm: assert property (p_norm) else $error("outputs altered in normal run");
   a_nostrap: assert property (p_nostrap) else $error("test without strap");
   a_ready: assert property (p_ready) else $error("no ready");
   a_pulse: assert property (p_pulse) else $error("ready too long");
   a_err: assert property (p_err) else $error("error without ready");
   c_ref: cover property (test_active && outputs_ref);
   c_hiz: cover property (test_active && outputs_hiz);
   c_err: cover property (pslverr);
endmodule
bind ctms_top ctms_chk chk_u (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .test_latch_select_pin, .outputs_hiz, .outputs_ref, .test_active);

//--- test/ctms_top_test.sv
// self-checking bench for ctms_top
`timescale 1ns/1ps
module ctms_top_test;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic        pready, pslverr, hiz, ref_o, act, strap = 0, osel = 0, lsp, osp;
   logic [32:0] expq[$];
   logic [15:0] lfsr = 16'h3B90;
   int          miscompares = 0, samples_checked = 0, cyc = 0;
   always #5 pclk = ~pclk;
   ctms_board brd_u (.strap_set(strap), .sel_set(osel), .test_latch_select_pin(lsp), .test_output_select_pin(osp));
   ctms_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .test_latch_select_pin(lsp), .test_output_select_pin(osp), .outputs_hiz(hiz), .outputs_ref(ref_o),
      .test_active(act));
   // ====
   // bus, reset and reporting tasks
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input string n, input logic [32:0] seen, input logic [32:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s exp %h seen %h", n, exp, seen);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1;
      // ready judged at the rising edge, request held until then
      do @(posedge pclk); while (pready !== 1);
      {psel, penable} <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      repeat (3) @(posedge pclk);
      expq.push_back(e);
      xfer(0, a, 0);
   endtask
   task automatic por(input logic s);
      @(posedge pclk);
      presetn <= 0;
      strap <= s;
      repeat (20) @(posedge pclk);
      presetn <= 1;
   endtask
   always @(posedge pclk)
      if (psel && penable && pready === 1 && !pwrite)
      begin
         check("read", {pslverr, prdata}, expq[0]);
         if (paddr == 12'h004)
            check("pins", {30'h0, act, ref_o, hiz}, {30'h0, |expq[0][1:0], expq[0][3], expq[0][2]});
         void'(expq.pop_front());
      end
   always @(posedge pclk)
   begin
      cyc++;
      lfsr <= lfsr_next(lfsr);
      if (cyc == 3000)
      begin
         miscompares++;
         test_done;
      end
   end
   // ====
   // scenarios
   initial
   begin
      por(0);
      rd(0, 0);
      xfer(1, 0, {lfsr, 16'h2});
      rd(4, 0);
      xfer(1, 0, {lfsr, 16'h1});
      repeat (4)
      begin
         osel <= lfsr[0];
         rd(4, 6);
      end
      xfer(1, 0, {lfsr, 16'h2});
      rd(4, 33'hA);
      rd(12'h8, 33'h100000000);
      por(1);
      for (int i = 0; i < 4; i++)
      begin
         osel <= i[1];
         xfer(1, 0, {lfsr, 14'h0, i[0], lfsr[0]});
         rd(4, i == 0 ? 33'h5 : 33'h9);
      end
      osel <= 0;
      xfer(1, 0, 0);
      rd(4, 5);
      test_done;
   end
endmodule
